// ===== rtl/aspc_pkg.sv
// package: constants and types for the sample-phase control block
package aspc_pkg;
  localparam int          NUM_CH        = 6;
  localparam int          NUM_ADC       = 3;
  localparam int          DATA_W        = 10;
  localparam int          GAIN_W        = 8;
  localparam int          OFFS_W        = 11;
  localparam int          COARSE_W      = 5;
  localparam int          SLOTS         = 7;
  localparam int          LATENCY       = 11;
  localparam int          SLOT_ADV      = 4;
  localparam logic [1:0]  PHASE_RST_6CH = 2'h3;
  localparam logic [1:0]  PHASE_RST_3CH = 2'h1;
  localparam logic [1:0]  PHASE_LATEST  = 2'h3;
  localparam logic [2:0]  SLOT_LAST     = 3'h6;
  localparam logic [3:0]  LAT_LAST      = 4'ha;
  localparam logic [GAIN_W-1:0]   GAIN_RST   = 8'h00;
  localparam logic [OFFS_W-1:0]   FINE_RST   = 11'h400;
  localparam logic [COARSE_W-1:0] COARSE_RST = 5'h10;

  typedef struct packed {
    logic       clamp_request_in;
    logic       black_clamp_in;
    logic [3:0] general_purpose_inputs;
  } aspc_ctrl_t;

  typedef struct packed {
    logic                wr;
    logic [2:0]          ch;
    logic [GAIN_W-1:0]   gain;
    logic [OFFS_W-1:0]   fine;
    logic [COARSE_W-1:0] coarse;
  } aspc_cal_wr_t;

  typedef enum logic {ASPC_SIX, ASPC_THREE} aspc_mode_t;
endpackage

// ===== rtl/aspc_phase_gen.sv
// phase generator: quarter-pixel sampling strobe selection
`timescale 1ns/100ps
module aspc_phase_gen
  import aspc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       pixel_start_i,
  input  wire logic [1:0] phase_i,
  output logic            sample_o,
  output logic [1:0]      quarter_o
);
  logic [1:0] quarter;
  logic [1:0] next_quarter;
  logic       sample;
  logic       next_sample;

  always_comb begin
    next_quarter = pixel_start_i ? 2'h0 : quarter + 2'h1;
    // strobe fires earlier for lower codes
    next_sample  = (next_quarter == phase_i);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quarter <= 2'h0;
      sample  <= 1'b0;
    end else begin
      quarter <= next_quarter;
      sample  <= next_sample;
    end
  end

  assign sample_o  = sample;
  assign quarter_o = quarter;

  property p_strobe_pos;
    @(posedge clk_i) disable iff (!resetn_i)
      sample |-> quarter == $past(phase_i);
  endproperty
  a_strobe_pos: assert property (p_strobe_pos) else $error("strobe at wrong quarter");
endmodule

// ===== rtl/aspc_top.sv
// top: control latching, phase select, channel mux, calibration store, serializer
`timescale 1ns/100ps
module aspc_top
  import aspc_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  input  wire aspc_pkg::aspc_mode_t          mode_i,
  input  wire aspc_pkg::aspc_ctrl_t          ctrl_i,
  input  wire logic                          phase_wr_i,
  input  wire logic [1:0]                    phase_i,
  input  wire aspc_pkg::aspc_cal_wr_t        cal_i,
  input  wire logic                          pixel_start_i,
  input  wire logic [aspc_pkg::NUM_CH*aspc_pkg::DATA_W-1:0] ch_data_i,
  output aspc_pkg::aspc_ctrl_t               ctrl_o,
  output logic [1:0]                         phase_o,
  output logic [aspc_pkg::NUM_ADC*aspc_pkg::DATA_W-1:0]     adc_data_o,
  output logic                               adc_valid_o,
  output logic [aspc_pkg::NUM_ADC-1:0]       lane_o,
  output logic                               serial_output_clock_o,
  output logic [aspc_pkg::GAIN_W-1:0]        gain_o,
  output logic [aspc_pkg::OFFS_W-1:0]        fine_o,
  output logic [aspc_pkg::COARSE_W-1:0]      coarse_o,
  input  wire logic [2:0]                    cal_rd_ch_i
);
  import aspc_pkg::*;

  // legalise a phase code for the active mode
  function automatic logic [1:0] legal_phase(input aspc_mode_t m, input logic [1:0] p);
    legal_phase = (m == ASPC_THREE) ? {p[1], 1'b1} : p;
  endfunction

  // ---- control latching
  aspc_ctrl_t ctrl, next_ctrl;
  always_comb next_ctrl = ctrl_i;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) ctrl <= '0;
    else           ctrl <= next_ctrl;
  end
  assign ctrl_o = ctrl;

  // ---- phase select
  logic [1:0] phase, next_phase;
  logic       init_done, next_init_done;
  always_comb begin
    next_phase     = phase;
    next_init_done = 1'b1;
    if (!init_done)
      next_phase = (mode_i == ASPC_SIX) ? PHASE_RST_6CH : PHASE_RST_3CH;
    else if (phase_wr_i)
      next_phase = legal_phase(mode_i, phase_i);
    else
      next_phase = legal_phase(mode_i, phase);
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase     <= PHASE_LATEST;
      init_done <= 1'b0;
    end else begin
      phase     <= next_phase;
      init_done <= next_init_done;
    end
  end
  assign phase_o = phase;

  logic       sample;
  logic [1:0] quarter;
  aspc_phase_gen u_phase (
    .clk_i         (clk_i),
    .resetn_i      (resetn_i),
    .pixel_start_i (pixel_start_i),
    .phase_i       (phase),
    .sample_o      (sample),
    .quarter_o     (quarter)
  );

  // ---- sample capture, fixed staging and channel mux
  logic [NUM_CH*DATA_W-1:0]  held, next_held;
  logic [NUM_CH*DATA_W-1:0]  stage, next_stage;
  logic [NUM_ADC*DATA_W-1:0] mux, next_mux;
  logic                      mux_v, next_mux_v;
  always_comb begin
    next_held  = sample ? ch_data_i : held;
    // every phase code has sampled by quarter 0, so staging there fixes latency
    next_stage = (quarter == 2'h0) ? held : stage;
    next_mux_v = 1'b0;
    next_mux   = mux;
    // mux is driven on fixed quarters so latency is phase independent
    if (quarter == 2'h3 || (mode_i == ASPC_SIX && quarter == 2'h1)) begin
      next_mux_v = 1'b1;
      for (int a = 0; a < NUM_ADC; a++) begin
        if (mode_i == ASPC_SIX && quarter == 2'h3)
          next_mux[a*DATA_W +: DATA_W] = stage[(2*a+1)*DATA_W +: DATA_W];
        else
          next_mux[a*DATA_W +: DATA_W] = stage[(2*a)*DATA_W +: DATA_W];
      end
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      held  <= '0;
      stage <= '0;
      mux   <= '0;
      mux_v <= 1'b0;
    end else begin
      held  <= next_held;
      stage <= next_stage;
      mux   <= next_mux;
      mux_v <= next_mux_v;
    end
  end

  // ---- fixed latency pipeline
  logic [NUM_ADC*DATA_W-1:0] pipe_d [LATENCY-SLOT_ADV];
  logic                      pipe_v [LATENCY-SLOT_ADV];
  logic [NUM_ADC*DATA_W-1:0] next_pipe_d [LATENCY-SLOT_ADV];
  logic                      next_pipe_v [LATENCY-SLOT_ADV];
  always_comb begin
    next_pipe_d[0] = mux;
    next_pipe_v[0] = mux_v;
    for (int i = 1; i < LATENCY-SLOT_ADV; i++) begin
      next_pipe_d[i] = pipe_d[i-1];
      next_pipe_v[i] = pipe_v[i-1];
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < LATENCY-SLOT_ADV; i++) begin
        pipe_d[i] <= '0;
        pipe_v[i] <= 1'b0;
      end
    end else begin
      pipe_d <= next_pipe_d;
      pipe_v <= next_pipe_v;
    end
  end
  logic [NUM_ADC*DATA_W-1:0] adc_data;
  logic                      adc_valid;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      adc_data  <= '0;
      adc_valid <= 1'b0;
    end else begin
      adc_data  <= pipe_d[LATENCY-SLOT_ADV-1];
      adc_valid <= pipe_v[LATENCY-SLOT_ADV-1];
    end
  end
  assign adc_data_o  = adc_data;
  assign adc_valid_o = adc_valid;

  // ---- serializer: seven slots per output clock period
  logic [2:0]         slot, next_slot;
  logic [NUM_ADC*SLOTS-1:0] shreg, next_shreg;
  logic [NUM_ADC-1:0] lane, next_lane;
  logic               sclk, next_sclk;
  always_comb begin
    next_slot  = (slot == SLOT_LAST) ? 3'h0 : slot + 3'h1;
    next_shreg = shreg;
    if (slot == SLOT_LAST) begin
      for (int a = 0; a < NUM_ADC; a++)
        next_shreg[a*SLOTS +: SLOTS] = adc_data[a*DATA_W +: SLOTS];
    end
    for (int a = 0; a < NUM_ADC; a++)
      next_lane[a] = next_shreg[a*SLOTS + int'(next_slot)];
    next_sclk = (next_slot < 3'h4);
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot  <= SLOT_LAST;
      shreg <= '0;
      lane  <= '0;
      sclk  <= 1'b0;
    end else begin
      slot  <= next_slot;
      shreg <= next_shreg;
      lane  <= next_lane;
      sclk  <= next_sclk;
    end
  end
  assign lane_o                = lane;
  assign serial_output_clock_o = sclk;

  // ---- per-channel calibration store
  logic [GAIN_W-1:0]   gain   [NUM_CH];
  logic [OFFS_W-1:0]   fine   [NUM_CH];
  logic [COARSE_W-1:0] coarse [NUM_CH];
  logic [GAIN_W-1:0]   rd_gain;
  logic [OFFS_W-1:0]   rd_fine;
  logic [COARSE_W-1:0] rd_coarse;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        gain[c]   <= GAIN_RST;
        fine[c]   <= FINE_RST;
        coarse[c] <= COARSE_RST;
      end
      rd_gain   <= GAIN_RST;
      rd_fine   <= FINE_RST;
      rd_coarse <= COARSE_RST;
    end else begin
      if (cal_i.wr && int'(cal_i.ch) < NUM_CH) begin
        gain[cal_i.ch]   <= cal_i.gain;
        fine[cal_i.ch]   <= cal_i.fine;
        coarse[cal_i.ch] <= cal_i.coarse;
      end
      if (int'(cal_rd_ch_i) < NUM_CH) begin
        rd_gain   <= gain[cal_rd_ch_i];
        rd_fine   <= fine[cal_rd_ch_i];
        rd_coarse <= coarse[cal_rd_ch_i];
      end
    end
  end
  assign gain_o   = rd_gain;
  assign fine_o   = rd_fine;
  assign coarse_o = rd_coarse;

  // ---- assertions
  property p_ctrl_latch;
    @(posedge clk_i) disable iff (!resetn_i)
      init_done |=> ctrl_o == $past(ctrl_i);
  endproperty
  a_ctrl_latch: assert property (p_ctrl_latch) else $error("control not latched");

  property p_three_odd;
    @(posedge clk_i) disable iff (!resetn_i)
      (mode_i == ASPC_THREE && init_done) |=> phase_o[0];
  endproperty
  a_three_odd: assert property (p_three_odd) else $error("illegal 3ch phase");

  property p_rst6;
    @(posedge clk_i) disable iff (!resetn_i)
      (!init_done && mode_i == ASPC_SIX) |=> phase_o == 2'h3;
  endproperty
  a_rst6: assert property (p_rst6) else $error("6ch reset phase wrong");

  property p_rst3;
    @(posedge clk_i) disable iff (!resetn_i)
      (!init_done && mode_i == ASPC_THREE) |=> phase_o[0] == 1'b1;
  endproperty
  a_rst3: assert property (p_rst3) else $error("3ch reset phase wrong");

  property p_mux_fixed;
    @(posedge clk_i) disable iff (!resetn_i)
      mux_v |-> $past(quarter[0]);
  endproperty
  a_mux_fixed: assert property (p_mux_fixed) else $error("mux slot moved");

  property p_mux_pair;
    @(posedge clk_i) disable iff (!resetn_i)
      (mode_i == ASPC_SIX && quarter == 2'h1) |=>
        mux[DATA_W-1:0] == $past(stage[DATA_W-1:0]);
  endproperty
  a_mux_pair: assert property (p_mux_pair) else $error("mux pairing wrong");

  property p_cal_wr;
    @(posedge clk_i) disable iff (!resetn_i)
      (cal_i.wr && cal_i.ch == 3'h0) |=> gain[0] == $past(cal_i.gain);
  endproperty
  a_cal_wr: assert property (p_cal_wr) else $error("gain write lost");

  property p_latency;
    @(posedge clk_i) disable iff (!resetn_i)
      mux_v |-> ##8 adc_valid && adc_data == $past(mux, 8);
  endproperty
  a_latency: assert property (p_latency) else $error("pipeline latency wrong");

  property p_slots;
    @(posedge clk_i) disable iff (!resetn_i)
      (init_done && slot == SLOT_LAST) |=> slot == 3'h0 ##6 slot == SLOT_LAST;
  endproperty
  a_slots: assert property (p_slots) else $error("slot sequence wrong");
endmodule

// ===== test/aspc_timing_gen.sv
// timing generator model: control, pixel start and channel samples
`timescale 1ns/100ps
module aspc_timing_gen
  import aspc_pkg::*;
(
  input  wire logic                                   clk_i,
  output aspc_pkg::aspc_ctrl_t                        ctrl_o,
  output logic                                        pixel_start_o,
  output logic [aspc_pkg::NUM_CH*aspc_pkg::DATA_W-1:0] ch_data_o
);
  initial begin
    ctrl_o = '0;
    pixel_start_o = 1'b0;
    ch_data_o = '0;
  end
  // changed just after a rising edge, held through the next one
  task automatic put_ctrl(input aspc_ctrl_t c);
    @(posedge clk_i);
    ctrl_o <= c;
  endtask
  // one-cycle start pulse, new samples from quarter 0 for the whole pixel
  task automatic put_pixel(input logic [NUM_CH*DATA_W-1:0] d);
    @(posedge clk_i);
    pixel_start_o <= 1'b1;
    @(posedge clk_i);
    pixel_start_o <= 1'b0;
    ch_data_o <= d;
  endtask
endmodule

// ===== test/afe_sample_phase_control_test.sv
// testbench for the sample-phase control block
`timescale 1ns/100ps
module afe_sample_phase_control_test;
  import aspc_pkg::*;
  logic                      clk_i;
  logic                      resetn_i;
  aspc_mode_t                mode_i;
  aspc_ctrl_t                ctrl_i;
  logic                      phase_wr_i;
  logic [1:0]                phase_i;
  aspc_cal_wr_t              cal_i;
  logic                      pixel_start_i;
  logic [NUM_CH*DATA_W-1:0]  ch_data_i;
  aspc_ctrl_t                ctrl_o;
  logic [1:0]                phase_o;
  logic [NUM_ADC*DATA_W-1:0] adc_data_o;
  logic                      adc_valid_o;
  logic [NUM_ADC-1:0]        lane_o;
  logic                      serial_output_clock_o;
  logic [GAIN_W-1:0]         gain_o;
  logic [OFFS_W-1:0]         fine_o;
  logic [COARSE_W-1:0]       coarse_o;
  logic [2:0]                cal_rd_ch_i;
  int                        miscompares;
  int                        num_checks;
  int                        cycles;
  int                        lat_a;
  int                        lat_b;

  aspc_top aspc_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .mode_i(mode_i),
    .ctrl_i(ctrl_i), .phase_wr_i(phase_wr_i), .phase_i(phase_i), .cal_i(cal_i),
    .pixel_start_i(pixel_start_i), .ch_data_i(ch_data_i), .ctrl_o(ctrl_o),
    .phase_o(phase_o), .adc_data_o(adc_data_o), .adc_valid_o(adc_valid_o),
    .lane_o(lane_o), .serial_output_clock_o(serial_output_clock_o), .gain_o(gain_o),
    .fine_o(fine_o), .coarse_o(coarse_o), .cal_rd_ch_i(cal_rd_ch_i));
  aspc_timing_gen aspc_timing_gen_inst (.clk_i(clk_i), .ctrl_o(ctrl_i),
    .pixel_start_o(pixel_start_i), .ch_data_o(ch_data_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  function automatic logic [59:0] mk(input logic [9:0] b);
    for (int k = 0; k < NUM_CH; k++)
      mk[k*DATA_W +: DATA_W] = b + 10'(k);
  endfunction
  task automatic do_reset(input aspc_mode_t m);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    mode_i <= m;
    repeat (20) @(posedge clk_i);
    #1;
    chk({phase_o, gain_o, fine_o, coarse_o}, {2'h3, GAIN_RST, FINE_RST, COARSE_RST});
    @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) tick();
  endtask
  task automatic set_phase(input logic [1:0] c, input logic [1:0] exp);
    @(posedge clk_i);
    phase_wr_i <= 1'b1;
    phase_i <= c;
    @(posedge clk_i);
    phase_wr_i <= 1'b0;
    #1;
    chk(phase_o, exp);
  endtask
  task automatic cal_write(input logic [2:0] ch, input logic [23:0] v);
    @(posedge clk_i);
    cal_i <= {1'b1, ch, v};
    @(posedge clk_i);
    cal_i.wr <= 1'b0;
  endtask
  task automatic cal_read(input logic [2:0] ch, input logic [23:0] exp);
    @(posedge clk_i);
    cal_rd_ch_i <= ch;
    repeat (2) tick();
    chk({gain_o, fine_o, coarse_o}, exp);
  endtask
  // old samples settle, then new ones; count clocks to the first new even word
  task automatic measure(input logic [9:0] b, output int n);
    aspc_timing_gen_inst.put_pixel(mk(b ^ 10'h3ff));
    repeat (30) tick();
    aspc_timing_gen_inst.put_pixel(mk(b));
    n = 0;
    do begin
      tick();
      n++;
    end while (!(adc_valid_o === 1'b1 && adc_data_o === {b + 10'h4, b + 10'h2, b}) && n < 40);
    chk(n < 40, 1'b1);
  endtask
  task automatic test_serial();
    logic prev;
    logic [9:0] w;
    w = 10'h2b5;
    prev = 1'b1;
    aspc_timing_gen_inst.put_pixel({6{w}});
    repeat (40) tick();
    for (int i = 0; i < 16 && !(prev === 1'b0 && serial_output_clock_o === 1'b1); i++) begin
      prev = serial_output_clock_o;
      tick();
    end
    for (int s = 0; s < SLOTS; s++) begin
      chk({serial_output_clock_o, lane_o}, {s < 4, {3{w[s]}}});
      tick();
    end
  endtask

  initial begin
    resetn_i = 1'b0;
    mode_i = ASPC_SIX;
    phase_wr_i = 1'b0;
    phase_i = 2'h0;
    cal_i = '0;
    cal_rd_ch_i = 3'h0;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    do_reset(ASPC_SIX);
    chk(phase_o, PHASE_RST_6CH);
    aspc_timing_gen_inst.put_ctrl(aspc_ctrl_t'(6'h2a));
    aspc_timing_gen_inst.put_ctrl(aspc_ctrl_t'(6'h15));
    #1;
    chk(ctrl_o, 6'h2a);
    tick();
    chk(ctrl_o, 6'h15);
    for (int c = 0; c < 4; c++)
      set_phase(2'(c), 2'(c));
    cal_write(3'h2, {8'h5a, 11'h123, 5'h07});
    cal_write(3'h3, {8'ha5, 11'h456, 5'h19});
    cal_write(3'h6, {8'hff, 11'h7ff, 5'h1f});
    cal_read(3'h2, {8'h5a, 11'h123, 5'h07});
    cal_read(3'h3, {8'ha5, 11'h456, 5'h19});
    cal_read(3'h0, {GAIN_RST, FINE_RST, COARSE_RST});
    set_phase(2'h3, 2'h3);
    measure(10'h100, lat_a);
    repeat (4) begin
      tick();
      if (adc_valid_o === 1'b1) break;
    end
    chk(adc_data_o, {10'h105, 10'h103, 10'h101});
    set_phase(2'h0, 2'h0);
    measure(10'h180, lat_b);
    chk(lat_b, lat_a);
    test_serial();
    do_reset(ASPC_THREE);
    chk(phase_o[0], 1'b1);
    set_phase(2'h2, 2'h3);
    set_phase(2'h0, 2'h1);
    measure(10'h200, lat_a);
    chk(lat_a >= LATENCY, 1'b1);
    set_phase(2'h3, 2'h3);
    measure(10'h280, lat_b);
    chk(lat_b, lat_a);
    report_and_stop();
  end
endmodule
